// >>> design/epi_pkg.sv
package epi_pkg;

    // ---------------------------------------------------------------
    // Bus geometry
    // ---------------------------------------------------------------
    localparam int EPI_ADDR_W = 8;
    localparam int EPI_DATA_W = 32;
    localparam int EPI_STRB_W = 4;

    // ---------------------------------------------------------------
    // Register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] EPI_OFS_CTRL = 8'h00;
    localparam logic [7:0] EPI_OFS_EVT_STATUS = 8'h04;
    localparam logic [7:0] EPI_OFS_EVT_MASK = 8'h08;

    // ---------------------------------------------------------------
    // Status and control register fields
    // ---------------------------------------------------------------
    localparam int EPI_BIT_MODE = 0;
    localparam int EPI_BIT_IE = 1;
    localparam int EPI_BIT_ACK = 2;
    localparam int EPI_BIT_FLAG = 3;
    localparam int EPI_BIT_PE = 4;
    localparam int EPI_BIT_EDG = 5;
    localparam int EPI_BIT_PDD = 6;
    localparam logic [7:0] EPI_CTRL_RESET = 8'h00;

    // ---------------------------------------------------------------
    // Event status and mask fields
    // ---------------------------------------------------------------
    localparam int EPI_EVT_FLAG_SET = 0;
    localparam logic [0:0] EPI_EVT_RESET = 1'h0;

    // ---------------------------------------------------------------
    // Bus responses
    // ---------------------------------------------------------------
    localparam logic [1:0] EPI_RESP_OKAY = 2'h0;
    localparam logic [1:0] EPI_RESP_SLVERR = 2'h2;

endpackage : epi_pkg

// >>> design/epi_axil_slave.sv
`timescale 1ns/1ns
module epi_axil_slave
    import epi_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [EPI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [EPI_DATA_W-1:0] s_axi_wdata,
    input wire logic [EPI_STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [EPI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [EPI_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic wr_en,
    output logic [EPI_ADDR_W-1:0] wr_addr,
    output logic [EPI_DATA_W-1:0] wr_data,
    output logic [EPI_STRB_W-1:0] wr_strb,
    input wire logic wr_err,
    output logic rd_en,
    output logic [EPI_ADDR_W-1:0] rd_addr,
    input wire logic [EPI_DATA_W-1:0] rd_data,
    input wire logic rd_err
);

    typedef struct packed {
        logic aw_held;
        logic [EPI_ADDR_W-1:0] awaddr;
        logic w_held;
        logic [EPI_DATA_W-1:0] wdata;
        logic [EPI_STRB_W-1:0] wstrb;
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [EPI_DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } epi_axil_s;

    epi_axil_s st;
    epi_axil_s next_st;

    // ---------------------------------------------------------------
    // Channel handshakes
    // ---------------------------------------------------------------
    // Address and data are held separately so they may arrive in either order.
    always_comb
    begin
        next_st = st;
        wr_en = 1'b0;
        rd_en = 1'b0;
        if (st.bvalid && s_axi_bready)
        begin
            next_st.bvalid = 1'b0;
        end
        if (s_axi_awvalid && st.awready)
        begin
            next_st.aw_held = 1'b1;
            next_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready)
        begin
            next_st.w_held = 1'b1;
            next_st.wdata = s_axi_wdata;
            next_st.wstrb = s_axi_wstrb;
        end
        if (st.aw_held && st.w_held && !st.bvalid)
        begin
            wr_en = 1'b1;
            next_st.aw_held = 1'b0;
            next_st.w_held = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = wr_err ? EPI_RESP_SLVERR : EPI_RESP_OKAY;
        end
        next_st.awready = !next_st.aw_held && !next_st.bvalid;
        next_st.wready = !next_st.w_held && !next_st.bvalid;
        if (st.rvalid && s_axi_rready)
        begin
            next_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st.arready)
        begin
            rd_en = 1'b1;
            next_st.rvalid = 1'b1;
            next_st.rdata = rd_data;
            next_st.rresp = rd_err ? EPI_RESP_SLVERR : EPI_RESP_OKAY;
        end
        next_st.arready = !next_st.rvalid;
        if (!aresetn)
        begin
            next_st = '0;
        end
    end

    always_ff @(posedge aclk)
    begin
        st <= next_st;
    end

    assign wr_addr = st.awaddr;
    assign wr_data = st.wdata;
    assign wr_strb = st.wstrb;
    assign rd_addr = s_axi_araddr;
    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;

endmodule : epi_axil_slave

// >>> design/epi_top.sv
// How it works
// - Pin enable gates all pin events.
// - Read-only event flag at bit 3.
// - Acknowledge bit 2: write one clears, reads zero.
// - Level mode: flag stays while pin asserted.
// - Interrupt enable bit 1 drives CPU request.
// - Mode bit 0: edges only, or edges plus levels.
// - Polarity bit 5; rising sense disables pullup.
// - Pull disable bit 6 turns pull off.
// - Enabling pin sets flag; software acknowledges first.
// - Asynchronous wake path bypasses clocked detector.
//
// Our own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
module epi_top
    import epi_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [EPI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [EPI_DATA_W-1:0] s_axi_wdata,
    input wire logic [EPI_STRB_W-1:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [EPI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [EPI_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic pin_in,
    output logic pull_enable,
    output logic event_request,
    output logic irq,
    output logic wake_request
);

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
        logic pe;
        logic edg;
        logic pdd;
        logic ie;
        logic mode;
        logic flag;
        logic evt_status;
        logic evt_mask;
        logic pull;
        logic req;
        logic irq;
    } epi_state_s;

    epi_state_s st;
    epi_state_s next_st;

    logic wr_en;
    logic [EPI_ADDR_W-1:0] wr_addr;
    logic [EPI_DATA_W-1:0] wr_data;
    logic [EPI_STRB_W-1:0] wr_strb;
    logic wr_err;
    logic rd_en;
    logic [EPI_ADDR_W-1:0] rd_addr;
    logic [EPI_DATA_W-1:0] rd_data;
    logic rd_err;
    logic active_now;
    logic active_prev;
    logic edge_det;
    logic level_hold;
    logic flag_set;
    logic ack_wr;
    logic ctrl_wr;
    logic [7:0] ctrl_view;

    // ---------------------------------------------------------------
    // Bus slave
    // ---------------------------------------------------------------
    epi_axil_slave epi_axil_slave_i (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .wr_en(wr_en),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_err(wr_err),
        .rd_en(rd_en),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    // ---------------------------------------------------------------
    // Address decode and read data
    // ---------------------------------------------------------------
    assign wr_err = !(wr_addr == EPI_OFS_CTRL || wr_addr == EPI_OFS_EVT_STATUS
                      || wr_addr == EPI_OFS_EVT_MASK);
    assign rd_err = !(rd_addr == EPI_OFS_CTRL || rd_addr == EPI_OFS_EVT_STATUS
                      || rd_addr == EPI_OFS_EVT_MASK);

    always_comb
    begin
        ctrl_view = EPI_CTRL_RESET;
        ctrl_view[EPI_BIT_MODE] = st.mode;
        ctrl_view[EPI_BIT_IE] = st.ie;
        ctrl_view[EPI_BIT_FLAG] = st.flag;
        ctrl_view[EPI_BIT_PE] = st.pe;
        ctrl_view[EPI_BIT_EDG] = st.edg;
        ctrl_view[EPI_BIT_PDD] = st.pdd;
    end

    always_comb
    begin
        rd_data = '0;
        case (rd_addr)
            EPI_OFS_CTRL: rd_data[7:0] = ctrl_view;
            EPI_OFS_EVT_STATUS: rd_data[EPI_EVT_FLAG_SET] = st.evt_status;
            EPI_OFS_EVT_MASK: rd_data[EPI_EVT_FLAG_SET] = st.evt_mask;
            default: rd_data = '0;
        endcase
    end

    // ---------------------------------------------------------------
    // Pin detection
    // ---------------------------------------------------------------
    // polarity selects active sense
    assign active_now = st.edg ? st.sync2 : !st.sync2;
    assign active_prev = st.edg ? st.prev : !st.prev;
    assign edge_det = active_now && !active_prev;
    assign level_hold = st.pe && st.mode && active_now;
    assign ctrl_wr = wr_en && wr_addr == EPI_OFS_CTRL && wr_strb[0];
    assign ack_wr = ctrl_wr && wr_data[EPI_BIT_ACK];

    // edges, plus levels in mode 1
    assign flag_set = (st.pe && (edge_det || level_hold))
                      || (ctrl_wr && wr_data[EPI_BIT_PE] && !st.pe);

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        next_st.sync1 = pin_in;
        next_st.sync2 = st.sync1;
        next_st.prev = st.sync2;
        if (ctrl_wr)
        begin
            next_st.mode = wr_data[EPI_BIT_MODE];
            next_st.ie = wr_data[EPI_BIT_IE];
            next_st.pe = wr_data[EPI_BIT_PE];
            next_st.edg = wr_data[EPI_BIT_EDG];
            next_st.pdd = wr_data[EPI_BIT_PDD];
        end
        if (wr_en && wr_addr == EPI_OFS_EVT_MASK && wr_strb[0])
        begin
            next_st.evt_mask = wr_data[EPI_EVT_FLAG_SET];
        end
        if (ack_wr && !level_hold)
        begin
            next_st.flag = 1'b0;
        end
        if (flag_set)
        begin
            next_st.flag = 1'b1;
        end
        if (wr_en && wr_addr == EPI_OFS_EVT_STATUS && wr_strb[0]
            && wr_data[EPI_EVT_FLAG_SET])
        begin
            next_st.evt_status = 1'b0;
        end
        if (next_st.flag && !st.flag)
        begin
            next_st.evt_status = 1'b1;
        end
        next_st.pull = next_st.pe && !next_st.pdd && !next_st.edg;
        next_st.req = next_st.flag && next_st.ie;
        next_st.irq = next_st.evt_status && next_st.evt_mask;
        if (!aresetn)
        begin
            next_st = '0;
            next_st.pe = EPI_CTRL_RESET[EPI_BIT_PE];
            next_st.edg = EPI_CTRL_RESET[EPI_BIT_EDG];
            next_st.pdd = EPI_CTRL_RESET[EPI_BIT_PDD];
            next_st.ie = EPI_CTRL_RESET[EPI_BIT_IE];
            next_st.mode = EPI_CTRL_RESET[EPI_BIT_MODE];
            next_st.evt_status = EPI_EVT_RESET;
            next_st.evt_mask = EPI_EVT_RESET;
        end
    end

    always_ff @(posedge aclk)
    begin
        st <= next_st;
    end

    assign pull_enable = st.pull;
    assign event_request = st.req;
    assign irq = st.irq;

    assign wake_request = st.pe && (pin_in == st.edg);

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_ENABLE_GATE: assert property (
        (!st.pe && !next_st.pe) |=> !$rose(st.flag))
        else $error("Flag rose while pin function disabled.");

    AST_FLAG_READ: assert property (
        (rd_en && rd_addr == EPI_OFS_CTRL) |=> s_axi_rdata[EPI_BIT_FLAG] == $past(st.flag))
        else $error("Read flag bit differs from flag.");

    AST_ACK_READ_ZERO: assert property (
        s_axi_rvalid |-> !s_axi_rdata[EPI_BIT_ACK])
        else $error("Acknowledge bit read as one.");

    AST_ACK_CLEARS: assert property (
        (ack_wr && !level_hold && !flag_set) |=> !st.flag)
        else $error("Acknowledge did not clear flag.");

    AST_LEVEL_HOLD: assert property (
        (st.flag && level_hold) |=> st.flag)
        else $error("Flag cleared while pin held asserted in level mode.");

    AST_REQUEST: assert property (
        event_request == (st.flag && st.ie))
        else $error("CPU request does not follow flag and enable.");

    AST_EDGE_SETS: assert property (
        (st.pe && edge_det) |=> st.flag)
        else $error("Edge of selected polarity did not set flag.");

    AST_PULL: assert property (
        pull_enable == (st.pe && !st.pdd && !st.edg))
        else $error("Pull control wrong.");

    AST_SPURIOUS: assert property (
        $rose(st.pe) |-> st.flag)
        else $error("Enabling pin did not set flag.");

    AST_SYNC_EDGE: assert property (
        (st.pe && !st.edg && $past(st.sync2) && !st.sync2 && $stable(st.edg)) |=> st.flag)
        else $error("Falling synchronised edge missed.");

    AST_IRQ: assert property (
        $rose(st.evt_status) && st.evt_mask |-> irq)
        else $error("Masked-in status did not raise irq.");

endmodule : epi_top

// >>> tb/epi_pin_src.sv
`timescale 1ns/1ns
module epi_pin_src
#(
    parameter logic EXT_PULL = 1'b1
)
(
    input wire logic drive_en,
    input wire logic drive_val,
    input wire logic pull_enable,
    output logic pin
);
    // pull level
    // A released pin rests at the internal pullup, else at the board pull.
    assign pin = drive_en ? drive_val : (pull_enable ? 1'b1 : EXT_PULL);
endmodule : epi_pin_src

// >>> tb/epi_top_tb.sv
`timescale 1ns/1ns
module epi_top_tb
    import epi_pkg::*;
;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [EPI_ADDR_W-1:0] awaddr = '0, araddr = '0;
    logic [EPI_DATA_W-1:0] wdata = '0, rdata, rd_val;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pin, pull_en, evt_req, irq, wake;
    logic [1:0] bresp, rresp, rsp;
    logic drv_en = 1'b0, drv_val = 1'b1;
    int bad_count = 0, num_checks = 0;

    always #20 aclk = ~aclk;

    epi_top epi_top_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .pin_in(pin), .pull_enable(pull_en),
        .event_request(evt_req), .irq(irq), .wake_request(wake));

    epi_pin_src epi_pin_src_i (.drive_en(drv_en), .drive_val(drv_val),
        .pull_enable(pull_en), .pin(pin));

    // ---------------------------------------------------------------
    // Bus and check tasks
    // ---------------------------------------------------------------
    task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task complete_run;
        if (bad_count == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready)
                awvalid <= 1'b0;
            if (wready)
                wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        rsp = bresp;
    endtask : wr

    task rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready)
                arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        rd_val = rdata;
        rsp = rresp;
    endtask : rd

    task rchk(input string what, input logic [7:0] a, input logic [31:0] e);
        rd(a);
        chk(what, rd_val, e);
    endtask : rchk

    // The pin needs two sync stages and one detect edge, so five cycles settle it.
    task pin_set(input logic en, input logic v);
        drv_en <= en;
        drv_val <= v;
        repeat (5) @(posedge aclk);
    endtask : pin_set

    // ---------------------------------------------------------------
    // Tests
    // ---------------------------------------------------------------
    initial
    begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rchk("ctrl reset", EPI_OFS_CTRL, 32'h0);
        chk("read resp", {30'h0, rsp}, {30'h0, EPI_RESP_OKAY});
        rd(8'h0c);
        chk("unmapped resp", {30'h0, rsp}, {30'h0, EPI_RESP_SLVERR});
        wr(8'h0c, 32'h0);
        chk("unmapped wr resp", {30'h0, rsp}, {30'h0, EPI_RESP_SLVERR});
        wr(EPI_OFS_CTRL, 32'h10);
        chk("write resp", {30'h0, rsp}, {30'h0, EPI_RESP_OKAY});
        rchk("flag on enable", EPI_OFS_CTRL, 32'h18);
        chk("pullup on", {31'h0, pull_en}, 32'h1);
        wr(EPI_OFS_CTRL, 32'h14);
        rchk("ack clears", EPI_OFS_CTRL, 32'h10);
        pin_set(1'b1, 1'b0);
        rchk("falling edge", EPI_OFS_CTRL, 32'h18);
        chk("no request polled", {31'h0, evt_req}, 32'h0);
        chk("wake low level", {31'h0, wake}, 32'h1);
        wr(EPI_OFS_CTRL, 32'h14);
        rchk("edge ack while low", EPI_OFS_CTRL, 32'h10);
        pin_set(1'b0, 1'b1);
        wr(EPI_OFS_CTRL, 32'h11);
        pin_set(1'b1, 1'b0);
        wr(EPI_OFS_CTRL, 32'h15);
        rchk("level ack held", EPI_OFS_CTRL, 32'h19);
        pin_set(1'b0, 1'b1);
        wr(EPI_OFS_CTRL, 32'h15);
        rchk("level ack done", EPI_OFS_CTRL, 32'h11);
        wr(EPI_OFS_CTRL, 32'h12);
        pin_set(1'b1, 1'b0);
        chk("request on flag", {31'h0, evt_req}, 32'h1);
        wr(EPI_OFS_CTRL, 32'h16);
        repeat (3) @(posedge aclk);
        chk("request cleared", {31'h0, evt_req}, 32'h0);
        pin_set(1'b0, 1'b1);
        rchk("status sticky", EPI_OFS_EVT_STATUS, 32'h1);
        chk("irq masked", {31'h0, irq}, 32'h0);
        wr(EPI_OFS_EVT_MASK, 32'h1);
        repeat (3) @(posedge aclk);
        chk("irq unmasked", {31'h0, irq}, 32'h1);
        wr(EPI_OFS_EVT_STATUS, 32'h1);
        repeat (3) @(posedge aclk);
        chk("irq cleared", {31'h0, irq}, 32'h0);
        wr(EPI_OFS_CTRL, 32'h30);
        repeat (3) @(posedge aclk);
        chk("pullup off rising", {31'h0, pull_en}, 32'h0);
        pin_set(1'b1, 1'b0);
        rchk("falling ignored first", EPI_OFS_CTRL, 32'h30);
        pin_set(1'b1, 1'b1);
        rchk("rising edge", EPI_OFS_CTRL, 32'h38);
        chk("wake high level", {31'h0, wake}, 32'h1);
        wr(EPI_OFS_CTRL, 32'h34);
        pin_set(1'b1, 1'b0);
        rchk("falling ignored", EPI_OFS_CTRL, 32'h30);
        pin_set(1'b0, 1'b1);
        wr(EPI_OFS_CTRL, 32'h50);
        repeat (3) @(posedge aclk);
        chk("pull disabled", {31'h0, pull_en}, 32'h0);
        wr(EPI_OFS_CTRL, 32'h04);
        pin_set(1'b1, 1'b0);
        rchk("pin disabled", EPI_OFS_CTRL, 32'h0);
        chk("no wake disabled", {31'h0, wake}, 32'h0);
        pin_set(1'b0, 1'b1);
        complete_run;
    end

    initial
    begin
        #400000;
        bad_count++;
        complete_run;
    end
endmodule : epi_top_tb
